// [hw/pms_pkg.sv]
package pms_pkg;
  // widths of the message port, the link side and the registers
  localparam int unsigned KIND_W    = 5;
  localparam int unsigned PARAM_W   = 8;
  localparam int unsigned SKIND_W   = 3;
  localparam int unsigned PAYLOAD_W = 32;
  localparam int unsigned CNT_W     = 4;
  localparam int unsigned PARAMS_W  = 64;
  localparam int unsigned PF_W      = 2;
  localparam int unsigned VF_W      = 6;
  localparam int unsigned APB_AW    = 8;
  localparam int unsigned IRQ_W     = 3;

  // receive timing counts
  localparam logic [CNT_W-1:0] MIN_ARRIVED_CYCLES = 4'h1;
  localparam logic [CNT_W-1:0] MAX_PARAM_BYTES    = 4'h8;

  // send message kind codes, 3'h4 to 3'h7 reserved
  localparam logic [SKIND_W-1:0] SK_LTR  = 3'h0;
  localparam logic [SKIND_W-1:0] SK_OBFF = 3'h1;
  localparam logic [SKIND_W-1:0] SK_SSPL = 3'h2;
  localparam logic [SKIND_W-1:0] SK_PME  = 3'h3;

  // defined payload bits of each kind
  localparam logic [PAYLOAD_W-1:0] MASK_LTR  = 32'h9fff_9fff;
  localparam logic [PAYLOAD_W-1:0] MASK_OBFF = 32'h0000_000f;
  localparam logic [PAYLOAD_W-1:0] MASK_SSPL = 32'h0000_03ff;
  localparam logic [PAYLOAD_W-1:0] MASK_PME  = 32'h0000_03f3;
  localparam int unsigned PME_PF_LSB = 0;
  localparam int unsigned PME_VF_LSB = 4;

  // register offsets
  localparam logic [APB_AW-1:0] OFS_CTRL    = 8'h00;
  localparam logic [APB_AW-1:0] OFS_DATA    = 8'h04;
  localparam logic [APB_AW-1:0] OFS_STATUS  = 8'h08;
  localparam logic [APB_AW-1:0] OFS_RX_INFO = 8'h0c;
  localparam logic [APB_AW-1:0] OFS_RX_DATA = 8'h10;
  localparam logic [APB_AW-1:0] OFS_IRQ_ST  = 8'h14;
  localparam logic [APB_AW-1:0] OFS_IRQ_CLR = 8'h18;
  localparam logic [APB_AW-1:0] OFS_IRQ_EN  = 8'h1c;

  // field positions
  localparam int unsigned CTRL_GO_BIT  = 0;
  localparam int unsigned CTRL_KIND_LSB = 4;
  localparam int unsigned ST_BUSY_BIT  = 0;
  localparam int unsigned RXI_CNT_LSB  = 8;
  localparam int unsigned IRQ_DONE_BIT = 0;
  localparam int unsigned IRQ_RX_BIT   = 1;
  localparam int unsigned IRQ_REF_BIT  = 2;

  // receive and send state machines
  typedef enum logic [0:0] {RX_IDLE = 1'b0, RX_SEND = 1'b1} pms_rx_st_t;
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_LINK = 2'b01, TX_DONE = 2'b10} pms_tx_st_t;

  // kinds above the pme code are reserved
  function automatic logic pms_kind_reserved(input logic [SKIND_W-1:0] k);
    return k > SK_PME;
  endfunction

  // defined payload bits for a kind
  function automatic logic [PAYLOAD_W-1:0] pms_payload_mask(input logic [SKIND_W-1:0] k);
    logic [PAYLOAD_W-1:0] m;
    m = '0;
    if (k == SK_LTR) m = MASK_LTR;
    else if (k == SK_OBFF) m = MASK_OBFF;
    else if (k == SK_SSPL) m = MASK_SSPL;
    else if (k == SK_PME) m = MASK_PME;
    return m;
  endfunction
endpackage

// [hw/pms_if.sv]
`timescale 1ns/1ns
interface pms_if;
  import pms_pkg::*;
  // received message report
  logic                 msg_arrived;
  logic [KIND_W-1:0]    msg_kind;
  logic [PARAM_W-1:0]   msg_param;
  // send message handshake
  logic                 send_req;
  logic [SKIND_W-1:0]   send_kind;
  logic [PAYLOAD_W-1:0] send_payload;
  logic                 send_done;

  modport dev (
    output msg_arrived, msg_kind, msg_param, send_done,
    input  send_req, send_kind, send_payload
  );
  modport usr (
    input  msg_arrived, msg_kind, msg_param, send_done,
    output send_req, send_kind, send_payload
  );
endinterface

// [hw/pms_param_ser.sv]
`timescale 1ns/1ns
module pms_param_ser (
  // clock, reset, freeze
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          clk_en,
  // control
  input  wire logic                          load,
  input  wire logic                          shift,
  input  wire logic                          clear,
  input  wire logic [pms_pkg::PARAMS_W-1:0] params,
  // byte out
  output logic      [pms_pkg::PARAM_W-1:0]  byte_q
);
  import pms_pkg::*;

  logic [PARAMS_W-1:0] sr_q;

  // byte stream, lowest byte first, zero when idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr_q <= '0;
    end else if (clk_en) begin
      if (load) begin
        sr_q <= params;
      end else if (clear) begin
        sr_q <= '0;
      end else if (shift) begin
        sr_q <= {{PARAM_W{1'b0}}, sr_q[PARAMS_W-1:PARAM_W]};
      end
    end
  end

  assign byte_q = sr_q[PARAM_W-1:0];
endmodule

// [hw/pms_dev_end.sv]
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ns
// What this block does
// - arrived flag high one or more cycles
// - parameters streamed bytewise while flag high
// - flag low one cycle between messages
// - flag only when receive port attribute set
// - five-bit kind code valid with flag
// - user holds request, kind, payload until complete
// - send kinds: ltr, obff, sspl, pme; rest reserved
// - ltr payload holds snoop and no-snoop latencies
// - obff code low nibble; sspl scale and value
// - pme payload selects pf and vf functions
// - one-cycle complete pulse per handled request
module pms_dev_end (
  // clock, reset, freeze
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           clk_en,
  // configuration strap
  input  wire logic                           receive_message_port_enable_attr,
  // link receive side
  input  wire logic                           lnk_rx_valid,
  input  wire logic [pms_pkg::KIND_W-1:0]    lnk_rx_kind,
  input  wire logic [pms_pkg::CNT_W-1:0]     lnk_rx_nbytes,
  input  wire logic [pms_pkg::PARAMS_W-1:0]  lnk_rx_params,
  output logic                                lnk_rx_ready,
  // link transmit side
  output logic                                lnk_tx_valid,
  output logic      [pms_pkg::SKIND_W-1:0]   lnk_tx_kind,
  output logic      [pms_pkg::PAYLOAD_W-1:0] lnk_tx_payload,
  output logic      [pms_pkg::PF_W-1:0]      lnk_tx_pf_sel,
  output logic      [pms_pkg::VF_W-1:0]      lnk_tx_vf_sel,
  input  wire logic                           lnk_tx_ready,
  output logic                                tx_reserved_drop,
  // user side message port
  pms_if.dev                                  mp
);
  import pms_pkg::*;

  // pme function selects out of a payload
  function automatic logic [PF_W-1:0] pme_pf(input logic [PAYLOAD_W-1:0] p);
    return p[PME_PF_LSB +: PF_W];
  endfunction

  function automatic logic [VF_W-1:0] pme_vf(input logic [PAYLOAD_W-1:0] p);
    return p[PME_VF_LSB +: VF_W];
  endfunction

  // number of flag cycles for a byte count
  function automatic logic [CNT_W-1:0] flag_cycles(input logic [CNT_W-1:0] n);
    logic [CNT_W-1:0] c;
    c = n;
    if (n < MIN_ARRIVED_CYCLES) c = MIN_ARRIVED_CYCLES;
    else if (n > MAX_PARAM_BYTES) c = MAX_PARAM_BYTES;
    return c;
  endfunction

  logic                 cap_done_q;
  logic                 en_attr_q;
  pms_rx_st_t           rx_st_q;
  logic [CNT_W-1:0]     rx_cnt_q;
  logic                 arrived_q;
  logic [KIND_W-1:0]    kind_q;
  logic                 rx_take;
  logic                 rx_start;
  logic                 rx_last;
  pms_tx_st_t           tx_st_q;
  logic                 done_q;
  logic                 drop_q;
  logic                 tx_valid_q;
  logic [SKIND_W-1:0]   tx_kind_q;
  logic [PAYLOAD_W-1:0] tx_payload_q;
  logic [PF_W-1:0]      tx_pf_q;
  logic [VF_W-1:0]      tx_vf_q;
  logic                 tx_take;
  logic [PARAMS_W-1:0]  rx_params;

  // strap caught at the first enabled edge after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_done_q <= 1'b0;
      en_attr_q  <= 1'b0;
    end else if (clk_en && !cap_done_q) begin
      cap_done_q <= 1'b1;
      en_attr_q  <= receive_message_port_enable_attr;
    end
  end

  // link message taken only from idle; idle itself is the gap
  assign lnk_rx_ready = clk_en && cap_done_q && (rx_st_q == RX_IDLE);
  assign rx_take      = lnk_rx_ready && lnk_rx_valid;
  // discarded without report while the port is disabled
  assign rx_start     = rx_take && en_attr_q;
  assign rx_last      = (rx_st_q == RX_SEND) && (rx_cnt_q == MIN_ARRIVED_CYCLES);

  // receive state and cycle count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q  <= RX_IDLE;
      rx_cnt_q <= '0;
    end else if (clk_en) begin
      case (rx_st_q)
        RX_IDLE: begin
          if (rx_start) begin
            rx_st_q  <= RX_SEND;
            rx_cnt_q <= flag_cycles(lnk_rx_nbytes);
          end
        end
        RX_SEND: begin
          if (rx_last) begin
            rx_st_q <= RX_IDLE;
          end else begin
            rx_cnt_q <= rx_cnt_q - MIN_ARRIVED_CYCLES;
          end
        end
        default: begin
          rx_st_q <= RX_IDLE;
        end
      endcase
    end
  end

  // arrived flag and kind, both cleared at the end of a message
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arrived_q <= 1'b0;
      kind_q    <= '0;
    end else if (clk_en) begin
      if (rx_start) begin
        arrived_q <= 1'b1;
        kind_q    <= lnk_rx_kind;
      end else if (rx_last) begin
        arrived_q <= 1'b0;
        kind_q    <= '0;
      end
    end
  end

  // a message without parameters shows zero bytes
  assign rx_params = (lnk_rx_nbytes == '0) ? '0 : lnk_rx_params;

  // parameter bytes, one per flag cycle
  pms_param_ser pms_param_ser_inst (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .load    (rx_start),
    .shift   ((rx_st_q == RX_SEND) && !rx_last),
    .clear   (rx_last),
    .params  (rx_params),
    .byte_q  (mp.msg_param)
  );

  assign mp.msg_arrived = arrived_q;
  assign mp.msg_kind    = kind_q;

  // request taken once; the user holds it until done
  assign tx_take = (tx_st_q == TX_IDLE) && mp.send_req;

  // send state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q <= TX_IDLE;
    end else if (clk_en) begin
      case (tx_st_q)
        TX_IDLE: begin
          if (tx_take && pms_kind_reserved(mp.send_kind)) begin
            tx_st_q <= TX_DONE;
          end else if (tx_take) begin
            tx_st_q <= TX_LINK;
          end
        end
        TX_LINK: begin
          if (lnk_tx_ready) begin
            tx_st_q <= TX_DONE;
          end
        end
        TX_DONE: begin
          tx_st_q <= TX_IDLE;
        end
        default: begin
          tx_st_q <= TX_IDLE;
        end
      endcase
    end
  end

  // message to the link, held until the link takes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid_q   <= 1'b0;
      tx_kind_q    <= '0;
      tx_payload_q <= '0;
      tx_pf_q      <= '0;
      tx_vf_q      <= '0;
    end else if (clk_en) begin
      if (tx_take && !pms_kind_reserved(mp.send_kind)) begin
        tx_valid_q   <= 1'b1;
        tx_kind_q    <= mp.send_kind;
        tx_payload_q <= mp.send_payload;
        if (mp.send_kind == SK_PME) begin
          tx_pf_q <= pme_pf(mp.send_payload);
          tx_vf_q <= pme_vf(mp.send_payload);
        end else begin
          tx_pf_q <= '0;
          tx_vf_q <= '0;
        end
      end else if ((tx_st_q == TX_LINK) && lnk_tx_ready) begin
        tx_valid_q <= 1'b0;
      end
    end
  end

  // one-cycle done after the link took it, or after a drop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
      drop_q <= 1'b0;
    end else if (clk_en) begin
      done_q <= ((tx_st_q == TX_LINK) && lnk_tx_ready) ||
                (tx_take && pms_kind_reserved(mp.send_kind));
      drop_q <= tx_take && pms_kind_reserved(mp.send_kind);
    end
  end

  assign mp.send_done     = done_q;
  assign tx_reserved_drop = drop_q;
  assign lnk_tx_valid     = tx_valid_q;
  assign lnk_tx_kind      = tx_kind_q;
  assign lnk_tx_payload   = tx_payload_q;
  assign lnk_tx_pf_sel    = tx_pf_q;
  assign lnk_tx_vf_sel    = tx_vf_q;
endmodule

// [hw/pms_usr_end.sv]
`timescale 1ns/1ns
module pms_usr_end (
  // clock, reset, freeze
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           clk_en,
  // apb slave
  input  wire logic [pms_pkg::APB_AW-1:0]    paddr,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  // interrupt
  output logic                                irq,
  // message port
  pms_if.usr                                  mp
);
  import pms_pkg::*;

  logic                 req_q;
  logic [SKIND_W-1:0]   skind_q;
  logic [PAYLOAD_W-1:0] payload_q;
  logic [SKIND_W-1:0]   ctrl_kind_q;
  logic [PAYLOAD_W-1:0] data_q;
  logic [IRQ_W-1:0]     irq_st_q;
  logic [IRQ_W-1:0]     irq_en_q;
  logic [KIND_W-1:0]    rx_kind_q;
  logic [CNT_W-1:0]     rx_cnt_q;
  logic [31:0]          rx_data_q;
  logic                 arr_prev_q;
  logic [31:0]          prdata_q;
  logic [31:0]          rd_val;
  logic                 hit;
  logic                 wr;
  logic                 go;
  logic [SKIND_W-1:0]   go_kind;
  logic                 refuse;
  logic [IRQ_W-1:0]     ev;
  logic [IRQ_W-1:0]     clr;

  // address decode and read value
  always_comb begin
    rd_val = '0;
    hit    = 1'b1;
    if (paddr == OFS_CTRL) begin
      rd_val[CTRL_KIND_LSB +: SKIND_W] = ctrl_kind_q;
    end else if (paddr == OFS_DATA) begin
      rd_val = data_q;
    end else if (paddr == OFS_STATUS) begin
      rd_val[ST_BUSY_BIT] = req_q;
    end else if (paddr == OFS_RX_INFO) begin
      rd_val[KIND_W-1:0] = rx_kind_q;
      rd_val[RXI_CNT_LSB +: CNT_W] = rx_cnt_q;
    end else if (paddr == OFS_RX_DATA) begin
      rd_val = rx_data_q;
    end else if (paddr == OFS_IRQ_ST) begin
      rd_val[IRQ_W-1:0] = irq_st_q;
    end else if (paddr == OFS_IRQ_CLR) begin
      rd_val = '0;
    end else if (paddr == OFS_IRQ_EN) begin
      rd_val[IRQ_W-1:0] = irq_en_q;
    end else begin
      hit = 1'b0;
    end
  end

  // zero-wait slave, frozen with the clock enable
  assign pready  = clk_en;
  assign pslverr = psel && penable && !hit;
  assign wr      = psel && penable && pwrite && clk_en && hit;
  assign go      = wr && (paddr == OFS_CTRL) && pwdata[CTRL_GO_BIT];
  assign go_kind = pwdata[CTRL_KIND_LSB +: SKIND_W];
  // reserved kinds and go while busy never reach the port
  assign refuse  = go && (req_q || pms_kind_reserved(go_kind));
  assign clr     = (wr && (paddr == OFS_IRQ_CLR)) ? pwdata[IRQ_W-1:0] : '0;
  assign ev      = {refuse,
                    arr_prev_q && !mp.msg_arrived,
                    mp.send_done && req_q};
  assign irq     = |(irq_st_q & irq_en_q);
  assign prdata  = prdata_q;

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (clk_en && psel && !penable) begin
      prdata_q <= rd_val;
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_kind_q <= '0;
      data_q      <= '0;
      irq_en_q    <= '0;
    end else if (wr) begin
      if (paddr == OFS_CTRL) ctrl_kind_q <= go_kind;
      else if (paddr == OFS_DATA) data_q <= pwdata;
      else if (paddr == OFS_IRQ_EN) irq_en_q <= pwdata[IRQ_W-1:0];
    end
  end

  // request held unchanged until done, dropped the cycle after
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q     <= 1'b0;
      skind_q   <= '0;
      payload_q <= '0;
    end else if (clk_en) begin
      if (req_q && mp.send_done) begin
        req_q <= 1'b0;
      end else if (go && !refuse) begin
        req_q     <= 1'b1;
        skind_q   <= go_kind;
        payload_q <= data_q & pms_payload_mask(go_kind);
      end
    end
  end

  assign mp.send_req     = req_q;
  assign mp.send_kind    = skind_q;
  assign mp.send_payload = payload_q;

  // received message capture, last four bytes kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arr_prev_q <= 1'b0;
      rx_kind_q  <= '0;
      rx_cnt_q   <= '0;
      rx_data_q  <= '0;
    end else if (clk_en) begin
      arr_prev_q <= mp.msg_arrived;
      if (mp.msg_arrived && !arr_prev_q) begin
        rx_kind_q <= mp.msg_kind;
        rx_cnt_q  <= MIN_ARRIVED_CYCLES;
        rx_data_q <= {24'h00_0000, mp.msg_param};
      end else if (mp.msg_arrived) begin
        rx_cnt_q  <= rx_cnt_q + MIN_ARRIVED_CYCLES;
        rx_data_q <= {rx_data_q[23:0], mp.msg_param};
      end
    end
  end

  // sticky status, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_q <= '0;
    end else if (clk_en) begin
      irq_st_q <= (irq_st_q & ~clr) | ev;
    end
  end
endmodule

// [verif/pms_checker.sv]
`timescale 1ns/1ns
module pms_checker (
  // clock and reset
  input wire logic                           pclk,
  input wire logic                           presetn,
  // received message report
  input wire logic                           msg_arrived,
  input wire logic [pms_pkg::KIND_W-1:0]    msg_kind,
  input wire logic [pms_pkg::PARAM_W-1:0]   msg_param,
  // send handshake
  input wire logic                           send_req,
  input wire logic [pms_pkg::SKIND_W-1:0]   send_kind,
  input wire logic [pms_pkg::PAYLOAD_W-1:0] send_payload,
  input wire logic                           send_done
);
  import pms_pkg::*;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // send side
  a_done_single: assert property (send_done |=> !send_done)
    else $error("send done longer than one cycle");
  a_done_with_req: assert property (send_done |-> send_req)
    else $error("send done without a request");
  a_done_latency: assert property ($rose(send_req) |-> !send_done [*2] ##[1:60] send_done)
    else $error("send done too early or missing");
  a_req_held: assert property (send_req && !send_done |=> send_req && $stable(send_kind) && $stable(send_payload))
    else $error("request changed before done");
  a_req_drop: assert property (send_done |=> !send_req)
    else $error("request kept after done");
  a_kind_legal: assert property (send_req |-> send_kind <= SK_PME)
    else $error("reserved send kind presented");

  // receive side
  a_flag_bounded: assert property (msg_arrived [*8] |=> !msg_arrived)
    else $error("arrived flag longer than eight cycles");
  a_kind_steady: assert property (msg_arrived && $past(msg_arrived) |-> $stable(msg_kind))
    else $error("kind changed while flag high");
  a_idle_quiet: assert property (!msg_arrived |-> msg_kind == '0 && msg_param == '0)
    else $error("kind or param nonzero while idle");

  // main scenarios
  c_send: cover property (send_req ##1 send_done);
  c_multi: cover property (msg_arrived ##1 msg_arrived);
  c_long: cover property (msg_arrived [*8]);
endmodule

// [verif/tb_pcie_message_side_channel.sv]
`timescale 1ns/1ns
module tb_pcie_message_side_channel;
  import pms_pkg::*;
  // clock, reset, strap
  logic                 pclk;
  logic                 presetn;
  logic                 clk_en;
  logic                 strap;
  // link side
  logic                 rx_valid;
  logic [KIND_W-1:0]    rx_kind;
  logic [CNT_W-1:0]     rx_nbytes;
  logic [PARAMS_W-1:0]  rx_params;
  logic                 rx_ready;
  logic                 tx_valid;
  logic [SKIND_W-1:0]   tx_kind;
  logic [PAYLOAD_W-1:0] tx_payload;
  logic [PF_W-1:0]      tx_pf;
  logic [VF_W-1:0]      tx_vf;
  logic                 tx_ready;
  // apb and bookkeeping
  logic [APB_AW-1:0]    paddr;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [31:0]          pwdata;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 irq;
  logic [31:0]          rd;
  logic                 err;
  int                   miscompares;
  int                   check_count;

  pms_if mp_if ();

  pms_dev_end pms_dev_end_inst (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .receive_message_port_enable_attr(strap),
    .lnk_rx_valid(rx_valid), .lnk_rx_kind(rx_kind), .lnk_rx_nbytes(rx_nbytes),
    .lnk_rx_params(rx_params), .lnk_rx_ready(rx_ready),
    .lnk_tx_valid(tx_valid), .lnk_tx_kind(tx_kind), .lnk_tx_payload(tx_payload),
    .lnk_tx_pf_sel(tx_pf), .lnk_tx_vf_sel(tx_vf), .lnk_tx_ready(tx_ready),
    .tx_reserved_drop(), .mp(mp_if)
  );
  pms_usr_end pms_usr_end_inst (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .mp(mp_if)
  );
  pms_checker pms_checker_inst (
    .pclk(pclk), .presetn(presetn), .msg_arrived(mp_if.msg_arrived),
    .msg_kind(mp_if.msg_kind), .msg_param(mp_if.msg_param), .send_req(mp_if.send_req),
    .send_kind(mp_if.send_kind), .send_payload(mp_if.send_payload),
    .send_done(mp_if.send_done)
  );

  // 20 mhz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer, result in rd and err
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // offer one message and follow its report byte by byte
  task automatic rx_msg(input logic [4:0] k, input logic [3:0] n, input logic [63:0] p);
    int i;
    int m;
    m = (n == 0) ? 1 : n;
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_kind <= k;
    rx_nbytes <= n;
    rx_params <= p;
    @(negedge pclk);
    while (rx_ready !== 1'b1) @(negedge pclk);
    @(posedge pclk);
    rx_valid <= 1'b0;
    for (i = 0; i < m; i++) begin
      @(negedge pclk);
      chk({mp_if.msg_arrived, mp_if.msg_kind}, {1'b1, k});
      chk(mp_if.msg_param, (n == 0) ? 8'h00 : p[i*8+:8]);
    end
    @(negedge pclk);
    chk(mp_if.msg_arrived, 1'b0);
  endtask

  // send one message through the registers, link stalled st cycles
  task automatic snd(input logic [2:0] k, input logic [31:0] p, input int st);
    logic [31:0] m;
    int          i;
    case (k)
      3'h0: m = 32'h9fff_9fff;
      3'h1: m = 32'h0000_000f;
      3'h2: m = 32'h0000_03ff;
      default: m = 32'h0000_03f3;
    endcase
    apb(1'b1, OFS_DATA, p);
    apb(1'b1, OFS_CTRL, {25'h0, k, 4'h1});
    i = 0;
    while (tx_valid !== 1'b1 && i < 20) begin
      @(negedge pclk);
      i++;
    end
    chk(tx_kind, k);
    chk(tx_payload, p & m);
    chk({tx_vf, tx_pf}, (k == SK_PME) ? {p[9:4], p[1:0]} : 8'h00);
    repeat (st) @(negedge pclk);
    chk({tx_valid, mp_if.send_req, mp_if.send_done}, 3'b110);
    @(posedge pclk);
    tx_ready <= 1'b1;
    i = 0;
    while (mp_if.send_done !== 1'b1 && i < 10) begin
      @(negedge pclk);
      i++;
    end
    chk(mp_if.send_done, 1'b1);
    @(posedge pclk);
    tx_ready <= 1'b0;
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[0], 1'b0);
    apb(1'b0, OFS_IRQ_ST, 32'h0);
    chk(rd[2:0], 3'h1);
    apb(1'b1, OFS_IRQ_CLR, 32'h1);
  endtask

  // received messages, registers and interrupt
  task t_receive;
    rx_msg(5'h10, 4'h0, 64'h0000_0000_0000_00a5);
    rx_msg(5'h14, 4'h3, 64'h0000_0000_0033_2211);
    rx_msg(5'h1f, 4'h8, 64'h0123_4567_89ab_cdef);
    apb(1'b0, OFS_RX_INFO, 32'h0);
    chk(rd[4:0], 5'h1f);
    apb(1'b0, OFS_RX_DATA, 32'h0);
    chk(rd, 32'h6745_2301);
    apb(1'b0, OFS_IRQ_ST, 32'h0);
    chk(rd[1], 1'b1);
    chk(irq, 1'b1);
    apb(1'b1, OFS_IRQ_CLR, 32'h7);
    @(negedge pclk);
    chk(irq, 1'b0);
  endtask

  // refused go, masked interrupt, unmapped address
  task t_refuse;
    int i;
    apb(1'b1, OFS_IRQ_EN, 32'h3);
    apb(1'b1, OFS_DATA, 32'h5);
    apb(1'b1, OFS_CTRL, {25'h0, SK_OBFF, 4'h1});
    apb(1'b1, OFS_CTRL, {25'h0, 3'h5, 4'h1});
    apb(1'b0, OFS_IRQ_ST, 32'h0);
    chk(rd[2], 1'b1);
    chk({irq, mp_if.send_kind}, {1'b0, SK_OBFF});
    apb(1'b1, OFS_IRQ_EN, 32'h7);
    @(negedge pclk);
    chk(irq, 1'b1);
    apb(1'b1, OFS_IRQ_CLR, 32'h4);
    @(negedge pclk);
    chk(irq, 1'b0);
    @(posedge pclk);
    tx_ready <= 1'b1;
    i = 0;
    while (mp_if.send_done !== 1'b1 && i < 10) begin
      @(negedge pclk);
      i++;
    end
    chk({mp_if.send_done, tx_kind}, {1'b1, SK_OBFF});
    @(posedge pclk);
    tx_ready <= 1'b0;
    apb(1'b1, OFS_IRQ_CLR, 32'h7);
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1);
  endtask

  // frozen clock enable holds the report mid-message
  task t_freeze;
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_kind <= 5'h03;
    rx_nbytes <= 4'h2;
    rx_params <= 64'h0000_0000_0000_5a3c;
    @(posedge pclk);
    rx_valid <= 1'b0;
    clk_en <= 1'b0;
    repeat (3) begin
      @(negedge pclk);
      chk({mp_if.msg_arrived, mp_if.msg_param}, {1'b1, 8'h3c});
    end
    @(posedge pclk);
    clk_en <= 1'b1;
    @(negedge pclk);
    chk({mp_if.msg_arrived, mp_if.msg_param}, {1'b1, 8'h3c});
    @(negedge pclk);
    chk({mp_if.msg_arrived, mp_if.msg_param}, {1'b1, 8'h5a});
    @(negedge pclk);
    chk(mp_if.msg_arrived, 1'b0);
  endtask

  // port disabled by strap after a second reset
  task t_strap;
    @(posedge pclk);
    presetn <= 1'b0;
    strap <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rx_valid <= 1'b1;
    repeat (12) begin
      @(negedge pclk);
      chk(mp_if.msg_arrived, 1'b0);
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
  endtask

  // verdict
  task conclude;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    #200000;
    miscompares++;
    conclude();
  end

  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, rx_valid, tx_ready} = '0;
    {paddr, pwdata, rx_kind, rx_nbytes, rx_params} = '0;
    clk_en = 1'b1;
    strap = 1'b1;
    miscompares = 0;
    check_count = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, OFS_IRQ_EN, 32'h7);
    t_receive();
    snd(3'h0, 32'hffff_ffff, 0);
    snd(3'h1, 32'hffff_fff5, 3);
    snd(3'h2, 32'h1234_5abc, 1);
    snd(3'h3, 32'hffff_fe3e, 5);
    t_refuse();
    t_freeze();
    t_strap();
    conclude();
  end
endmodule
